// ### rtl/dagmm_pkg.sv
// package: constants for the address generation and memory map block
package dagmm_pkg;
  localparam int ADDR_W = 24;
  localparam int IDX_W = 16;
  localparam int PAGE_W = 8;
  localparam int NPTR = 4;
  localparam int NMOD = 4;
  localparam int EXT_ADDR_W = 20;
  localparam int NBANK = 4;
  localparam int PG_BITS = 8;
  localparam logic [7:0] PAGE_INTERNAL = 8'h00;
  localparam logic [7:0] PAGE_BOOT = 8'hff;
  localparam logic [23:0] BOOT_ROM_BASE = 24'hff0000;
  localparam logic [15:0] BOOT_ROM_WORDS = 16'h1000;
  localparam logic [15:0] RAM_BLK_WORDS = 16'h1000;
  localparam logic [15:0] RAM0_BASE = 16'h0000;
  localparam logic [15:0] RAM1_BASE = 16'h2000;
  localparam int IO_PAGE_SHIFT = 10;
  localparam logic [7:0] IO_ONCHIP_LAST = 8'h1f;
  localparam logic [7:0] BANK0_START_RST = 8'h01;
  localparam logic [7:0] BANK1_START_RST = 8'h40;
  localparam logic [7:0] BANK2_START_RST = 8'h80;
  localparam logic [7:0] BANK3_START_RST = 8'hc0;
  localparam logic [7:0] BANK_LAST_PAGE = 8'hfe;
  localparam int CORE_CLK_MAX_MHZ = 160;
  localparam int PERIPH_CLK_MAX_MHZ = 80;
  // APB register map (byte addresses)
  localparam logic [7:0] REG_BANK0 = 8'h00;
  localparam logic [7:0] REG_BANK1 = 8'h04;
  localparam logic [7:0] REG_BANK2 = 8'h08;
  localparam logic [7:0] REG_BANK3 = 8'h0c;
  localparam logic [7:0] REG_EXTCFG = 8'h10;
  localparam logic [7:0] REG_CLKCFG = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_JPAGE = 8'h1c;
  localparam int EXTCFG_BYTE_MODE = 0;
  localparam int EXTCFG_PACK24 = 1;
  localparam int CLKCFG_HALF = 0;
  localparam logic CLK_HALF_RST = 1'b1;
  typedef enum logic [1:0] {DAGMM_MOD_NONE, DAGMM_MOD_PRE, DAGMM_MOD_POST} dagmm_mod_t;
  typedef enum logic [2:0] {DAGMM_SEQ_NEXT, DAGMM_SEQ_REL, DAGMM_SEQ_DIRECT,
                            DAGMM_SEQ_INDIRECT, DAGMM_SEQ_HOLD} dagmm_seq_t;
endpackage

// ### rtl/dagmm_addr_unit.sv
// data address unit: pointer, modify, length and base sets with shadow copy
`timescale 1ns/10ps
module dagmm_addr_unit
  import dagmm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_sec_sel,
  input wire logic i_wr_en,
  input wire logic [1:0] i_wr_kind,
  input wire logic [1:0] i_wr_idx,
  input wire logic [15:0] i_wr_data,
  input wire logic i_page_wr,
  input wire logic [7:0] i_page_data,
  input wire logic i_use,
  input wire logic [1:0] i_ptr,
  input wire logic [1:0] i_mod,
  input wire dagmm_mod_t i_mode,
  output logic [23:0] o_addr,
  output logic [15:0] o_ptr_val,
  output logic [7:0] o_page
);
  // storage index: {secondary, reg}
  logic [15:0] ptr_r [8];
  logic [15:0] mod_r [8];
  logic [15:0] len_r [8];
  logic [15:0] base_r [8];
  logic [2:0] pi;
  logic [2:0] mi;
  logic [2:0] wi;
  logic [15:0] cur;
  logic [15:0] step;
  logic [15:0] next_ptr;
  logic [16:0] off;
  logic [16:0] wrapped;

  assign pi = {i_sec_sel, i_ptr};
  assign mi = {i_sec_sel, i_mod};
  assign wi = {i_sec_sel, i_wr_idx};
  assign cur = ptr_r[pi];
  assign step = mod_r[mi];
  assign o_ptr_val = cur;

  // modulo update stays in 16 bits, so the page never changes
  always_comb begin
    off = 17'({1'b0, cur} - {1'b0, base_r[pi]} + {step[15], step});
    wrapped = off;
    if (len_r[pi] != 16'h0000) begin
      if (off[16]) begin
        wrapped = 17'(off + {1'b0, len_r[pi]});
      end else if (off >= {1'b0, len_r[pi]}) begin
        wrapped = 17'(off - {1'b0, len_r[pi]});
      end
      next_ptr = 16'(wrapped[15:0] + base_r[pi]);
    end else begin
      next_ptr = 16'(cur + step);
    end
  end

  // page above index forms the full address
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_addr <= 24'h000000;
    end else if (i_use) begin
      o_addr <= (i_mode == DAGMM_MOD_PRE) ? {o_page, next_ptr} : {o_page, cur};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_page <= 8'h00;
    end else if (i_page_wr) begin
      o_page <= i_page_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int k = 0; k < 8; k++) begin
        ptr_r[k] <= 16'h0000;
        mod_r[k] <= 16'h0000;
        len_r[k] <= 16'h0000;
        base_r[k] <= 16'h0000;
      end
    end else begin
      if (i_use && i_mode != DAGMM_MOD_NONE) begin
        ptr_r[pi] <= next_ptr;
      end
      if (i_wr_en) begin
        case (i_wr_kind)
          2'd0: ptr_r[wi] <= i_wr_data;
          2'd1: mod_r[wi] <= i_wr_data;
          2'd2: len_r[wi] <= i_wr_data;
          default: base_r[wi] <= i_wr_data;
        endcase
      end
    end
  end
endmodule

// ### rtl/dagmm_bank_decode.sv
// bank decode: picks the external bank select for a page
`timescale 1ns/10ps
module dagmm_bank_decode
  import dagmm_pkg::*;
(
  input wire logic [7:0] i_page,
  input wire logic [7:0] i_start0,
  input wire logic [7:0] i_start1,
  input wire logic [7:0] i_start2,
  input wire logic [7:0] i_start3,
  output logic [3:0] o_bank_sel
);
  // highest bank whose start is at or below the page wins
  always_comb begin
    o_bank_sel = 4'h0;
    if (i_page != PAGE_INTERNAL && i_page <= BANK_LAST_PAGE) begin
      if (i_page >= i_start3) begin
        o_bank_sel = 4'h8;
      end else if (i_page >= i_start2) begin
        o_bank_sel = 4'h4;
      end else if (i_page >= i_start1) begin
        o_bank_sel = 4'h2;
      end else if (i_page >= i_start0) begin
        o_bank_sel = 4'h1;
      end
    end
  end
endmodule

// ### rtl/dagmm_top.sv
// address generation and memory map decode with APB configuration
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module dagmm_top
  import dagmm_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_SEC_SEL,
  input wire logic I_UNIT_WR,
  input wire logic I_UNIT_WR_SEL,
  input wire logic [1:0] I_UNIT_WR_KIND,
  input wire logic [1:0] I_UNIT_WR_IDX,
  input wire logic [15:0] I_UNIT_WR_DATA,
  input wire logic I_PAGE0_WR,
  input wire logic I_PAGE1_WR,
  input wire logic [7:0] I_PAGE_DATA,
  input wire logic I_USE0,
  input wire logic [1:0] I_PTR0,
  input wire logic [1:0] I_MOD0,
  input wire dagmm_pkg::dagmm_mod_t I_MODE0,
  input wire logic I_USE1,
  input wire logic [1:0] I_PTR1,
  input wire logic [1:0] I_MOD1,
  input wire dagmm_pkg::dagmm_mod_t I_MODE1,
  input wire logic I_IO_ACC,
  input wire dagmm_pkg::dagmm_seq_t I_SEQ_OP,
  input wire logic [23:0] I_SEQ_IMM,
  input wire logic I_SEQ_IND_UNIT,
  input wire logic I_EXT_GRANT_PM,
  output logic [23:0] O_PROG_MEM_ADDR_BUS,
  output logic [23:0] O_DATA_MEM_ADDR_BUS,
  output logic [23:0] O_PC,
  output logic O_RAM0_SEL,
  output logic O_RAM1_SEL,
  output logic [11:0] O_RAM_IDX,
  output logic O_BOOT_SEL,
  output logic O_IOREG_SEL,
  output logic [3:0] O_BANK_SELECT_LINES,
  output logic O_IO_SPACE_SELECT,
  output logic [19:0] O_EXT_ADDR,
  output logic O_EXT_FROM_PM,
  output logic O_PERIPH_CLK_EN
);
  logic [7:0] bank_start [NBANK];
  logic [7:0] jump_page_reg;
  logic byte_mode;
  logic pack24;
  logic clk_half;
  logic clk_phase;
  logic [23:0] da0;
  logic [23:0] da1;
  logic [15:0] pv0;
  logic [15:0] pv1;
  logic [7:0] data_page_reg;
  logic [7:0] second_data_page_reg;
  logic [23:0] next_pc;
  logic [23:0] data_addr;
  logic [23:0] ext_src;
  logic [3:0] pm_bank;
  logic [3:0] dm_bank;
  logic pm_ext;
  logic dm_ext;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] next_rdata;
  logic err;

  // APB: zero wait states, error for unmapped offsets
  assign wr_acc = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_acc = I_PSEL && I_PENABLE && !I_PWRITE;
  assign O_PREADY = 1'b1;
  assign err = !(I_PADDR <= REG_JPAGE && I_PADDR[1:0] == 2'b00);
  assign O_PSLVERR = I_PSEL && I_PENABLE && err;

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      bank_start[0] <= BANK0_START_RST;
      bank_start[1] <= BANK1_START_RST;
      bank_start[2] <= BANK2_START_RST;
      bank_start[3] <= BANK3_START_RST;
    end else if (wr_acc && !err && I_PADDR <= REG_BANK3) begin
      bank_start[I_PADDR[3:2]] <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      byte_mode <= 1'b0;
      pack24 <= 1'b0;
    end else if (wr_acc && I_PADDR == REG_EXTCFG) begin
      byte_mode <= I_PWDATA[EXTCFG_BYTE_MODE];
      pack24 <= I_PWDATA[EXTCFG_PACK24];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      clk_half <= CLK_HALF_RST;
    end else if (wr_acc && I_PADDR == REG_CLKCFG) begin
      clk_half <= I_PWDATA[CLKCFG_HALF];
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      jump_page_reg <= 8'h00;
    end else if (wr_acc && I_PADDR == REG_JPAGE) begin
      jump_page_reg <= I_PWDATA[7:0];
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    case (I_PADDR)
      REG_BANK0: next_rdata = {24'h000000, bank_start[0]};
      REG_BANK1: next_rdata = {24'h000000, bank_start[1]};
      REG_BANK2: next_rdata = {24'h000000, bank_start[2]};
      REG_BANK3: next_rdata = {24'h000000, bank_start[3]};
      REG_EXTCFG: next_rdata = {30'h0, pack24, byte_mode};
      REG_CLKCFG: next_rdata = {31'h0, clk_half};
      REG_STATUS: next_rdata = {O_PC[7:0], second_data_page_reg, data_page_reg,
                                4'h0, O_BANK_SELECT_LINES};
      REG_JPAGE: next_rdata = {24'h000000, jump_page_reg};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // read data is registered in the setup phase so it is stable in the access phase
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PRDATA <= 32'h00000000;
    end else if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
      O_PRDATA <= next_rdata;
    end else if (rd_acc) begin
      O_PRDATA <= O_PRDATA;
    end
  end

  // peripheral clock enable: every cycle, or every second one
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      clk_phase <= 1'b0;
    end else begin
      clk_phase <= clk_half ? !clk_phase : 1'b1;
    end
  end
  assign O_PERIPH_CLK_EN = clk_half ? clk_phase : 1'b1;

  // both units share the context select
  dagmm_addr_unit u_unit0 (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_sec_sel(I_SEC_SEL),
    .i_wr_en(I_UNIT_WR && !I_UNIT_WR_SEL),
    .i_wr_kind(I_UNIT_WR_KIND),
    .i_wr_idx(I_UNIT_WR_IDX),
    .i_wr_data(I_UNIT_WR_DATA),
    .i_page_wr(I_PAGE0_WR),
    .i_page_data(I_PAGE_DATA),
    .i_use(I_USE0),
    .i_ptr(I_PTR0),
    .i_mod(I_MOD0),
    .i_mode(I_MODE0),
    .o_addr(da0),
    .o_ptr_val(pv0),
    .o_page(data_page_reg)
  );

  dagmm_addr_unit u_unit1 (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_sec_sel(I_SEC_SEL),
    .i_wr_en(I_UNIT_WR && I_UNIT_WR_SEL),
    .i_wr_kind(I_UNIT_WR_KIND),
    .i_wr_idx(I_UNIT_WR_IDX),
    .i_wr_data(I_UNIT_WR_DATA),
    .i_page_wr(I_PAGE1_WR),
    .i_page_data(I_PAGE_DATA),
    .i_use(I_USE1),
    .i_ptr(I_PTR1),
    .i_mod(I_MOD1),
    .i_mode(I_MODE1),
    .o_addr(da1),
    .o_ptr_val(pv1),
    .o_page(second_data_page_reg)
  );

  // program sequencer target selection
  always_comb begin
    case (I_SEQ_OP)
      DAGMM_SEQ_NEXT: next_pc = 24'(O_PC + 24'h000001);
      DAGMM_SEQ_REL: next_pc = 24'(O_PC + I_SEQ_IMM);
      DAGMM_SEQ_DIRECT: next_pc = I_SEQ_IMM;
      DAGMM_SEQ_INDIRECT: next_pc = {jump_page_reg, I_SEQ_IND_UNIT ? pv1 : pv0};
      DAGMM_SEQ_HOLD: next_pc = O_PC;
      default: next_pc = O_PC;
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      O_PC <= BOOT_ROM_BASE;
    end else begin
      O_PC <= next_pc;
    end
  end

  // the program bus carries the counter; unit 1 drives the data bus when in use, else unit 0
  assign O_PROG_MEM_ADDR_BUS = O_PC;
  assign data_addr = I_USE1 ? {second_data_page_reg, da1[15:0]} : da0;
  assign O_DATA_MEM_ADDR_BUS = data_addr;

  // page zero holds both RAM blocks; the rest of it is unmapped
  always_comb begin
    O_RAM0_SEL = data_addr[23:16] == PAGE_INTERNAL && data_addr[15:12] == RAM0_BASE[15:12];
    O_RAM1_SEL = data_addr[23:16] == PAGE_INTERNAL && data_addr[15:12] == RAM1_BASE[15:12];
    O_RAM_IDX = data_addr[11:0];
    O_BOOT_SEL = O_PC[23:16] == PAGE_BOOT && O_PC[15:0] < BOOT_ROM_WORDS;
  end

  // I/O page is address bits above the 1K offset
  assign O_IOREG_SEL = I_IO_ACC && data_addr[17:IO_PAGE_SHIFT] <= IO_ONCHIP_LAST;
  assign O_IO_SPACE_SELECT = I_IO_ACC && data_addr[17:IO_PAGE_SHIFT] > IO_ONCHIP_LAST;

  dagmm_bank_decode u_pm_dec (
    .i_page(O_PC[23:16]),
    .i_start0(bank_start[0]),
    .i_start1(bank_start[1]),
    .i_start2(bank_start[2]),
    .i_start3(bank_start[3]),
    .o_bank_sel(pm_bank)
  );

  // external data accesses take their page from the second unit
  dagmm_bank_decode u_dm_dec (
    .i_page(second_data_page_reg),
    .i_start0(bank_start[0]),
    .i_start1(bank_start[1]),
    .i_start2(bank_start[2]),
    .i_start3(bank_start[3]),
    .o_bank_sel(dm_bank)
  );

  assign pm_ext = pm_bank != 4'h0;
  // a data access in page zero stays internal whatever the second page holds
  assign dm_ext = dm_bank != 4'h0 && !I_IO_ACC && data_addr[23:16] != PAGE_INTERNAL;
  // data access wins the shared bus unless program fetch is granted
  always_comb begin
    O_EXT_FROM_PM = pm_ext && (!dm_ext || I_EXT_GRANT_PM);
    ext_src = O_EXT_FROM_PM ? O_PC : {second_data_page_reg, data_addr[15:0]};
    O_BANK_SELECT_LINES = O_EXT_FROM_PM ? pm_bank : (dm_ext ? dm_bank : 4'h0);
  end

  // byte mode doubles the word address; 24-bit packing on bytes triples it
  always_comb begin
    if (byte_mode && pack24) begin
      O_EXT_ADDR = 20'({ext_src[18:0], 1'b0} + {1'b0, ext_src[18:0]});
    end else if (byte_mode) begin
      O_EXT_ADDR = {ext_src[18:0], 1'b0};
    end else begin
      O_EXT_ADDR = ext_src[19:0];
    end
  end
endmodule

// ### bench/dagmm_top_checker.sv
// checker: port timing relations of the address generation block
`timescale 1ns/10ps
module dagmm_top_checker
  import dagmm_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire dagmm_pkg::dagmm_seq_t I_SEQ_OP,
  input wire logic [23:0] I_SEQ_IMM,
  input wire logic I_IO_ACC,
  input wire logic [23:0] O_PC,
  input wire logic [23:0] O_PROG_MEM_ADDR_BUS,
  input wire logic [23:0] O_DATA_MEM_ADDR_BUS,
  input wire logic O_RAM0_SEL,
  input wire logic O_RAM1_SEL,
  input wire logic [3:0] O_BANK_SELECT_LINES,
  input wire logic O_IO_SPACE_SELECT,
  input wire logic O_IOREG_SEL,
  input wire logic O_PERIPH_CLK_EN
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  a_pc_boot: assert property ($fell(I_RST) |-> O_PC == BOOT_ROM_BASE)
    else $error("counter does not start in boot rom");
  a_pc_hold: assert property (I_SEQ_OP == DAGMM_SEQ_HOLD |=> $stable(O_PC))
    else $error("counter moved on hold");
  a_pc_next: assert property (I_SEQ_OP == DAGMM_SEQ_NEXT |=> O_PC == $past(O_PC) + 24'h1)
    else $error("counter did not step by one");
  a_pc_rel: assert property (I_SEQ_OP == DAGMM_SEQ_REL |=>
    O_PC == $past(O_PC) + $past(I_SEQ_IMM)) else $error("relative target wrong");
  a_pc_direct: assert property (I_SEQ_OP == DAGMM_SEQ_DIRECT |=> O_PC == $past(I_SEQ_IMM))
    else $error("direct target wrong");
  a_periph_gap: assert property (!O_PERIPH_CLK_EN |=> O_PERIPH_CLK_EN)
    else $error("peripheral enable below half rate");
  a_bank_onehot: assert property ($onehot0(O_BANK_SELECT_LINES))
    else $error("more than one bank selected");
  a_io_select: assert property (O_IO_SPACE_SELECT |-> I_IO_ACC && !O_IOREG_SEL)
    else $error("io select without io access");
  a_ram_page: assert property (O_RAM0_SEL || O_RAM1_SEL |->
    O_DATA_MEM_ADDR_BUS[23:16] == 8'h00 || O_PROG_MEM_ADDR_BUS[23:16] == 8'h00)
    else $error("internal ram selected outside page zero");
  c_indirect: cover property (I_SEQ_OP == DAGMM_SEQ_INDIRECT);
  c_io_ext: cover property (O_IO_SPACE_SELECT);
  c_bank_top: cover property (O_BANK_SELECT_LINES[3]);
endmodule

// ### bench/dagmm_seq_source.sv
// partner: instruction source issuing one sequencer op per request
`timescale 1ns/10ps
module dagmm_seq_source
  import dagmm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire dagmm_pkg::dagmm_seq_t i_op,
  input wire logic [23:0] i_imm,
  output dagmm_pkg::dagmm_seq_t o_op,
  output logic [23:0] o_imm
);
  // idle slots are holds so the counter never drifts between requests
  always_ff @(posedge i_clk) begin
    o_op <= (i_go && !i_rst) ? i_op : DAGMM_SEQ_HOLD;
    o_imm <= i_rst ? 24'h0 : (i_go ? i_imm : ~o_imm);
  end
endmodule

// ### bench/tb.sv
// testbench: drives the address block and compares with a reference model
`timescale 1ns/10ps
module tb;
  import dagmm_pkg::*;
  logic I_CLK = 0, I_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_SEC_SEL = 0;
  logic I_UNIT_WR = 0, I_UNIT_WR_SEL = 0, I_PAGE0_WR = 0, I_PAGE1_WR = 0, I_USE0 = 0, I_USE1 = 0;
  logic I_IO_ACC = 0, I_SEQ_IND_UNIT = 0, I_EXT_GRANT_PM = 0, go = 0;
  logic [7:0] I_PADDR = 0, I_PAGE_DATA = 0;
  logic [31:0] I_PWDATA = 0, O_PRDATA;
  logic [1:0] I_UNIT_WR_KIND = 0, I_UNIT_WR_IDX = 0, I_PTR0 = 0, I_MOD0 = 0, I_PTR1 = 0, I_MOD1 = 0;
  logic [15:0] I_UNIT_WR_DATA = 0;
  dagmm_mod_t I_MODE0 = DAGMM_MOD_NONE, I_MODE1 = DAGMM_MOD_NONE;
  dagmm_seq_t I_SEQ_OP, req_op = DAGMM_SEQ_HOLD;
  logic [23:0] I_SEQ_IMM, req_imm = 0, O_PROG_MEM_ADDR_BUS, O_DATA_MEM_ADDR_BUS, O_PC;
  logic O_PREADY, O_PSLVERR, O_RAM0_SEL, O_RAM1_SEL, O_BOOT_SEL, O_IOREG_SEL;
  logic O_IO_SPACE_SELECT, O_EXT_FROM_PM, O_PERIPH_CLK_EN;
  logic [11:0] O_RAM_IDX;
  logic [3:0] O_BANK_SELECT_LINES;
  logic [19:0] O_EXT_ADDR;
  int fails = 0, samples_checked = 0, rg[2][2][4][4], pg, pcm, jp, st[4];

  always #50 I_CLK = ~I_CLK;

  dagmm_seq_source src (.i_clk(I_CLK), .i_rst(I_RST), .i_go(go), .i_op(req_op),
    .i_imm(req_imm), .o_op(I_SEQ_OP), .o_imm(I_SEQ_IMM));
  dagmm_top uut (.I_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA,
    .O_PREADY, .O_PSLVERR, .I_SEC_SEL, .I_UNIT_WR, .I_UNIT_WR_SEL, .I_UNIT_WR_KIND,
    .I_UNIT_WR_IDX, .I_UNIT_WR_DATA, .I_PAGE0_WR, .I_PAGE1_WR, .I_PAGE_DATA, .I_USE0, .I_PTR0,
    .I_MOD0, .I_MODE0, .I_USE1, .I_PTR1, .I_MOD1, .I_MODE1, .I_IO_ACC, .I_SEQ_OP, .I_SEQ_IMM,
    .I_SEQ_IND_UNIT, .I_EXT_GRANT_PM, .O_PROG_MEM_ADDR_BUS, .O_DATA_MEM_ADDR_BUS, .O_PC,
    .O_RAM0_SEL, .O_RAM1_SEL, .O_RAM_IDX, .O_BOOT_SEL, .O_IOREG_SEL, .O_BANK_SELECT_LINES,
    .O_IO_SPACE_SELECT, .O_EXT_ADDR, .O_EXT_FROM_PM, .O_PERIPH_CLK_EN);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // outputs are read before this edge's updates land, as the slave presented them
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge I_CLK);
    I_PSEL <= 1;
    I_PWRITE <= wr;
    I_PADDR <= a;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1;
    for (n = 0; n < 16; n++) begin
      @(posedge I_CLK);
      if (O_PREADY === 1'b1) break;
    end
    if (n == 16) begin
      fails++;
      report_and_stop();
    end
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 0;
    I_PENABLE <= 0;
  endtask

  task automatic uwr(input int u, k, i, d);
    @(posedge I_CLK);
    I_UNIT_WR <= 1;
    I_UNIT_WR_SEL <= u[0];
    I_UNIT_WR_KIND <= k[1:0];
    I_UNIT_WR_IDX <= i[1:0];
    I_UNIT_WR_DATA <= d[15:0];
    @(posedge I_CLK);
    I_UNIT_WR <= 0;
    rg[u][I_SEC_SEL][k][i] = d & 'hffff;
  endtask

  // both page registers move together; the external decode follows the second one
  task automatic page(input int p);
    @(posedge I_CLK);
    I_PAGE0_WR <= 1;
    I_PAGE1_WR <= 1;
    I_PAGE_DATA <= p[7:0];
    @(posedge I_CLK);
    I_PAGE0_WR <= 0;
    I_PAGE1_WR <= 0;
    pg = p;
  endtask

  task automatic use0(input int p, m, input dagmm_mod_t md);
    int q, nq, l, b, s;
    @(posedge I_CLK);
    I_USE0 <= 1;
    I_PTR0 <= p[1:0];
    I_MOD0 <= m[1:0];
    I_MODE0 <= md;
    @(posedge I_CLK);
    I_USE0 <= 0;
    q = rg[0][I_SEC_SEL][0][p];
    l = rg[0][I_SEC_SEL][2][p];
    b = rg[0][I_SEC_SEL][3][p];
    s = rg[0][I_SEC_SEL][1][m];
    if (s >= 'h8000)
      s -= 'h10000; // modify values are signed
    nq = q + s;
    if (l != 0)
      nq = b + ((nq - b) % l + l) % l;
    nq &= 'hffff;
    rg[0][I_SEC_SEL][0][p] = nq;
    #1;
    chk(O_DATA_MEM_ADDR_BUS, {pg[7:0], md == DAGMM_MOD_PRE ? nq[15:0] : q[15:0]});
  endtask

  task automatic seq(input dagmm_seq_t op, input int imm, input logic u, input int p);
    @(posedge I_CLK);
    go <= 1;
    req_op <= op;
    req_imm <= imm[23:0];
    I_SEQ_IND_UNIT <= u;
    I_PTR0 <= p[1:0];
    I_PTR1 <= p[1:0];
    @(posedge I_CLK);
    go <= 0;
    @(posedge I_CLK);
    #1;
    case (op)
      DAGMM_SEQ_NEXT: pcm += 1;
      DAGMM_SEQ_REL: pcm += imm;
      DAGMM_SEQ_DIRECT: pcm = imm;
      DAGMM_SEQ_INDIRECT: pcm = jp << 16 | rg[u][0][0][p];
      default: ;
    endcase
    pcm &= 'hffffff;
    chk(O_PC, pcm);
    chk(O_PROG_MEM_ADDR_BUS, pcm);
  endtask

  task automatic pclk(input int exp);
    int c = 0;
    repeat (8) begin
      @(posedge I_CLK);
      if (O_PERIPH_CLK_EN === 1'b1)
        c++;
    end
    chk(c, exp);
  endtask

  function automatic int bank(int p);
    bank = 0;
    if (p < 1 || p > 254)
      return 0;
    for (int k = 0; k < 4; k++)
      if (p >= st[k])
        bank = 1 << k;
  endfunction

  initial begin
    logic [31:0] rd;
    logic er;
    int exp_rst[8] = '{1, 'h40, 'h80, 'hc0, 0, 1, 0, 0};
    int pages[10] = '{0, 1, 'h3f, 'h40, 'h7f, 'h80, 'hbf, 'hc0, 'hfe, 'hff};
    void'($urandom(32'hec7b7518));
    st = '{1, 'h40, 'h80, 'hc0};
    pcm = 'hff0000;
    repeat (16) @(posedge I_CLK);
    I_RST <= 0;
    @(posedge I_CLK);
    #1;
    chk(O_PC, pcm);
    chk(O_BOOT_SEL, 1);
    for (int k = 0; k < 8; k++) begin
      apb(0, 8'(k * 4), 0, rd, er);
      chk(rd, exp_rst[k]);
    end
    apb(0, 8'h20, 0, rd, er);
    chk(er, 1);
    pclk(4);
    apb(1, REG_CLKCFG, 0, rd, er);
    pclk(8);
    uwr(0, 0, 0, 'h8000);
    repeat (2) begin
      foreach (pages[k]) begin
        page(pages[k]);
        use0(0, 1, DAGMM_MOD_POST);
        chk(O_BANK_SELECT_LINES, bank(pages[k]));
      end
      st[1] = 'h50;
      apb(1, REG_BANK1, 'h50, rd, er);
    end
    page('h83);
    @(posedge I_CLK);
    I_PAGE0_WR <= 1;
    I_PAGE_DATA <= 8'h05;
    @(posedge I_CLK);
    I_PAGE0_WR <= 0;
    pg = 5;
    use0(0, 1, DAGMM_MOD_POST);
    chk(O_BANK_SELECT_LINES, bank('h83));
    for (int k = 0; k < 3; k++) begin
      apb(1, REG_EXTCFG, k == 2 ? 3 : k, rd, er);
      #1;
      chk(O_EXT_ADDR, ('h38000 * (k + 1)) & 'hfffff);
    end
    apb(1, REG_EXTCFG, 0, rd, er);
    for (int r = 0; r < 4; r++) begin
      I_SEC_SEL <= r[0];
      for (int k = 0; k < 4; k++) begin
        if (r < 2)
          uwr(0, r == 0 ? 0 : 1, k, $urandom);
        if (r >= 2)
          uwr(0, 0, k, $urandom);
      end
    end
    for (int r = 0; r < 3; r++) begin
      I_SEC_SEL <= r[0];
      for (int k = 0; k < 4; k++) begin
        page($urandom_range(255));
        use0(k, 3 - k, r == 1 ? DAGMM_MOD_PRE : DAGMM_MOD_POST);
      end
    end
    I_SEC_SEL <= 0;
    uwr(0, 3, 2, 'hfff8);
    uwr(0, 2, 2, 8);
    uwr(0, 1, 2, 5);
    uwr(0, 0, 2, 'hfffe);
    repeat (6) use0(2, 2, DAGMM_MOD_POST);
    use0(2, 2, DAGMM_MOD_PRE);
    uwr(0, 1, 3, 'hfffd);
    repeat (4) use0(2, 3, DAGMM_MOD_POST);
    jp = 'h5a;
    apb(1, REG_JPAGE, jp, rd, er);
    uwr(1, 0, 3, 'h4321);
    seq(DAGMM_SEQ_NEXT, 0, 0, 0);
    seq(DAGMM_SEQ_REL, 'h10, 0, 0);
    seq(DAGMM_SEQ_REL, 'hfffff0, 0, 0);
    seq(DAGMM_SEQ_DIRECT, 'h123456, 0, 0);
    seq(DAGMM_SEQ_HOLD, 0, 0, 0);
    seq(DAGMM_SEQ_INDIRECT, 0, 0, 2);
    seq(DAGMM_SEQ_INDIRECT, 0, 1, 3);
    page('h83);
    use0(0, 1, DAGMM_MOD_POST);
    for (int k = 0; k < 2; k++) begin
      @(posedge I_CLK);
      I_EXT_GRANT_PM <= k[0];
      @(posedge I_CLK);
      #1;
      chk(O_EXT_FROM_PM, k);
      chk(O_BANK_SELECT_LINES, k ? bank(pcm >> 16) : bank('h83));
    end
    chk(O_EXT_ADDR, pcm & 'hfffff);
    @(posedge I_CLK);
    I_EXT_GRANT_PM <= 0;
    uwr(0, 1, 1, 0);
    I_IO_ACC <= 1;
    for (int k = 0; k < 2; k++) begin
      page(k ? 0 : 'hff);
      uwr(0, 0, 0, k ? 0 : 'hffff);
      use0(0, 1, DAGMM_MOD_POST);
      chk({O_IOREG_SEL, O_IO_SPACE_SELECT}, k ? 2 : 1);
    end
    I_IO_ACC <= 0;
    for (int k = 0; k < 2; k++) begin
      uwr(0, 0, 0, k ? 'h2005 : 'h0fff);
      use0(0, 1, DAGMM_MOD_POST);
      chk({O_RAM1_SEL, O_RAM0_SEL}, k ? 2 : 1);
      chk(O_RAM_IDX, k ? 5 : 'hfff);
      chk(O_PROG_MEM_ADDR_BUS, pcm);
    end
    report_and_stop();
  end
endmodule

bind dagmm_top dagmm_top_checker chk_i (.I_CLK, .I_RST, .I_SEQ_OP, .I_SEQ_IMM, .I_IO_ACC,
  .O_PC, .O_PROG_MEM_ADDR_BUS, .O_DATA_MEM_ADDR_BUS, .O_RAM0_SEL, .O_RAM1_SEL,
  .O_BANK_SELECT_LINES, .O_IO_SPACE_SELECT, .O_IOREG_SEL, .O_PERIPH_CLK_EN);
